// file: logic/extended_address_mapper.sv
// Address generation and memory mapping for an extended 8-bit core.
// Assumes core control inputs are synchronous to clk_i.
//
// What this block does
// - Code above the first 64 kB runs only with extended addressing enabled.
// - Constant reads above 64 kB of code need extended addressing enabled.
// - Program counter is 23 bits over one linear 8 MB code space.
// - In mixed mode, code up to the on-chip limit is internal, higher goes external.
// - Bus modes: mixed, single chip without bus, and no on-chip code.
// - Indexed code reads use data pointer, extended pointer, universal pointer or PC.
// - Fetch starts at 00:0000h after reset; vectors start at 00:0003h.
// - Universal accesses reach every space except special function registers.
// - Pointer zero uses registers 1-3, pointer one registers 5-7 of bank.
// - Universal map: external, high, internal, extended internal, then code on top.
// - Top pointer bit picks code; 00:0000-00:FFFF is classic external data.
// - Universal move adds a 0-3 displacement to the pointer before access.
// - Universal stores into the code region never change code memory.
// - Pointer increment adds 1 to 4 to a selected pointer in place.
// - Without extended mode only low 64 kB code, external data, internal and extended internal data are reached.
// - Without extended mode, reads outside those regions return FFh.
// - Opcode after prefix A5h runs in its extended alternate form.
// - Classic instructions keep their classic machine cycle counts.
// - Enable bit of core configuration governs upper code and high data.
// - Universal move reaches extended internal data whatever the enable bit.
module extended_address_mapper #(
  parameter logic [22:0] ONCHIP_TOP = 23'h017FFF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Core configuration
  input wire logic extended_addressing_enable_i,
  input wire mapper_pkg::bus_mode_t bus_mode_i,
  input wire logic [1:0] bank_sel_i,
  // Working register writes
  input wire logic reg_wr_i,
  input wire logic [2:0] reg_wr_idx_i,
  input wire logic [7:0] reg_wr_data_i,
  // Program counter control
  input wire logic pc_step_i,
  input wire logic [2:0] pc_step_len_i,
  input wire logic pc_load_i,
  input wire logic [22:0] pc_load_addr_i,
  // Opcode stream
  input wire logic opcode_valid_i,
  input wire logic [7:0] opcode_i,
  // Indexed code reads
  input wire logic cread_req_i,
  input wire mapper_pkg::base_sel_t cread_base_i,
  input wire logic cread_ptr_sel_i,
  input wire logic [7:0] acc_i,
  input wire logic [15:0] active_data_pointer_16_i,
  input wire logic [22:0] extended_data_pointer_i,
  // Universal move and increment
  input wire logic umove_req_i,
  input wire logic umove_write_i,
  input wire logic umove_ptr_sel_i,
  input wire logic [1:0] umove_disp_i,
  input wire logic uinc_req_i,
  input wire logic uinc_ptr_sel_i,
  input wire logic [1:0] uinc_amount_i,
  // Memory answer
  input wire logic mem_rvalid_i,
  input wire logic [7:0] mem_rdata_i,
  // Fetch side
  output logic [22:0] pc_o,
  output mapper_pkg::code_req_t fetch_o,
  output logic decoded_valid_o,
  output logic [7:0] decoded_opcode_o,
  output logic extended_form_o,
  // Code read side
  output mapper_pkg::code_req_t cread_o,
  // Universal move side
  output mapper_pkg::mem_req_t mem_req_o,
  output logic move_done_o,
  output logic [7:0] move_rdata_o,
  output logic move_dropped_o,
  output logic busy_o,
  output logic [23:0] uptr0_o,
  output logic [23:0] uptr1_o
);

  // ==========================================================================
  // Helpers
  function automatic logic [23:0] uadd(input logic [23:0] base, input logic [2:0] off);
    uadd = 24'(base + {21'h000000, off});
  endfunction

  typedef enum {ST_IDLE, ST_WAIT} move_state_t;

  // ==========================================================================
  // Working register banks
  logic [7:0] regs_mem [mapper_pkg::NUM_BANKS][mapper_pkg::REGS_PER_BANK];

  // Pointers assembled most significant byte first
  wire [23:0] uptr0_w = {regs_mem[bank_sel_i][mapper_pkg::PTR0_HI],
                         regs_mem[bank_sel_i][mapper_pkg::PTR0_MID],
                         regs_mem[bank_sel_i][mapper_pkg::PTR0_LO]};
  wire [23:0] uptr1_w = {regs_mem[bank_sel_i][mapper_pkg::PTR1_HI],
                         regs_mem[bank_sel_i][mapper_pkg::PTR1_MID],
                         regs_mem[bank_sel_i][mapper_pkg::PTR1_LO]};

  // Increment by 1 to 4, written back in place
  wire [23:0] uinc_src_w = uinc_ptr_sel_i ? uptr1_w : uptr0_w;
  wire [23:0] uinc_res_w = uadd(uinc_src_w, {1'b0, uinc_amount_i} + 3'h1);
  wire [2:0] uinc_hi_w = uinc_ptr_sel_i ? mapper_pkg::PTR1_HI : mapper_pkg::PTR0_HI;
  wire [2:0] uinc_mid_w = uinc_ptr_sel_i ? mapper_pkg::PTR1_MID : mapper_pkg::PTR0_MID;
  wire [2:0] uinc_lo_w = uinc_ptr_sel_i ? mapper_pkg::PTR1_LO : mapper_pkg::PTR0_LO;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int b = 0; b < mapper_pkg::NUM_BANKS; b++) begin
        for (int r = 0; r < mapper_pkg::REGS_PER_BANK; r++) begin
          regs_mem[b][r] <= mapper_pkg::REG_RESET;
        end
      end
    end else begin
      if (reg_wr_i) begin
        regs_mem[bank_sel_i][reg_wr_idx_i] <= reg_wr_data_i;
      end
      if (uinc_req_i) begin
        regs_mem[bank_sel_i][uinc_hi_w] <= uinc_res_w[23:16];
        regs_mem[bank_sel_i][uinc_mid_w] <= uinc_res_w[15:8];
        regs_mem[bank_sel_i][uinc_lo_w] <= uinc_res_w[7:0];
      end
    end
  end

  // ==========================================================================
  // Program counter: 23-bit linear, wraps inside 8 MB
  logic [22:0] pc_reg;
  logic [22:0] pc_next;

  assign pc_next = pc_load_i ? pc_load_addr_i :
                   pc_step_i ? 23'(pc_reg + {20'h00000, pc_step_len_i}) : pc_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_reg <= mapper_pkg::RESET_PC;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // ==========================================================================
  // Fetch routing, registered alongside the counter
  logic fetch_ext_w;
  logic fetch_fault_w;
  mapper_pkg::code_req_t fetch_reg;

  code_fetch_router #(.ONCHIP_TOP(ONCHIP_TOP)) fetch_router (
    .addr_i(pc_next),
    .ext_enable_i(extended_addressing_enable_i),
    .bus_mode_i(bus_mode_i),
    .external_o(fetch_ext_w),
    .fault_o(fetch_fault_w)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_reg <= '{valid: 1'b0, external: 1'b0, fault: 1'b0, addr: mapper_pkg::RESET_PC};
    end else begin
      fetch_reg <= '{valid: 1'b1, external: fetch_ext_w, fault: fetch_fault_w, addr: pc_next};
    end
  end

  // ==========================================================================
  // Prefix detection
  logic prefix_pending_reg;
  logic decoded_valid_reg;
  logic [7:0] decoded_opcode_reg;
  logic extended_form_reg;
  wire is_prefix = opcode_valid_i && !prefix_pending_reg
                   && (opcode_i == mapper_pkg::PREFIX_BYTE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prefix_pending_reg <= 1'b0;
      decoded_valid_reg <= 1'b0;
      decoded_opcode_reg <= 8'h00;
      extended_form_reg <= 1'b0;
    end else if (opcode_valid_i) begin
      prefix_pending_reg <= is_prefix;
      decoded_valid_reg <= !is_prefix;
      decoded_opcode_reg <= opcode_i;
      extended_form_reg <= !is_prefix && prefix_pending_reg;
    end else begin
      decoded_valid_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Indexed code reads
  wire [23:0] cread_uptr_w = cread_ptr_sel_i ? uptr1_w : uptr0_w;
  wire [15:0] active_data_pointer_16_sum_w = 16'(active_data_pointer_16_i + {8'h00, acc_i});
  logic [22:0] cread_addr_w;
  logic cread_ext_w;
  logic cread_fault_w;
  mapper_pkg::code_req_t cread_reg;

  assign cread_addr_w = (cread_base_i == mapper_pkg::BASE_ACTIVE_DATA_POINTER_16) ? {pc_reg[22:16], active_data_pointer_16_sum_w} :
                        (cread_base_i == mapper_pkg::BASE_EXTENDED_DATA_POINTER) ? 23'(extended_data_pointer_i + acc_i) :
                        (cread_base_i == mapper_pkg::BASE_UPTR) ? 23'(cread_uptr_w + acc_i) :
                        23'(pc_reg + acc_i);

  code_fetch_router #(.ONCHIP_TOP(ONCHIP_TOP)) cread_router (
    .addr_i(cread_addr_w),
    .ext_enable_i(extended_addressing_enable_i),
    .bus_mode_i(bus_mode_i),
    .external_o(cread_ext_w),
    .fault_o(cread_fault_w)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cread_reg <= '0;
    end else begin
      cread_reg <= '{valid: cread_req_i, external: cread_ext_w, fault: cread_fault_w,
                     addr: cread_addr_w};
    end
  end

  // ==========================================================================
  // Universal move
  wire [23:0] umove_ptr_w = umove_ptr_sel_i ? uptr1_w : uptr0_w;
  wire [23:0] umove_addr_w = uadd(umove_ptr_w, {1'b0, umove_disp_i});
  mapper_pkg::space_t umove_space_w;
  logic umove_reach_w;

  universal_map_decoder umove_decoder (
    .addr_i(umove_addr_w),
    .ext_enable_i(extended_addressing_enable_i),
    .space_o(umove_space_w),
    .reachable_o(umove_reach_w)
  );

  // Store to code is swallowed; unreachable read answers with FFh
  wire code_store_w = umove_write_i && (umove_space_w == mapper_pkg::SPACE_CODE);
  wire blocked_w = !umove_reach_w;
  logic busy_reg;
  wire move_go_w = umove_req_i && !busy_reg;
  wire issue_w = move_go_w && !code_store_w && !blocked_w;

  move_state_t state_reg;
  move_state_t state_next;
  mapper_pkg::mem_req_t mem_req_reg;
  logic move_done_reg;
  logic [7:0] move_rdata_reg;
  logic move_dropped_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (issue_w && !umove_write_i) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (mem_rvalid_i) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      mem_req_reg <= '0;
      move_done_reg <= 1'b0;
      move_rdata_reg <= 8'h00;
      move_dropped_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= (state_next == ST_WAIT);
      mem_req_reg <= '{valid: issue_w, write: umove_write_i, space: umove_space_w,
                       addr: umove_addr_w, wdata: acc_i};
      move_dropped_reg <= move_go_w && (code_store_w || (blocked_w && umove_write_i));
      // Read answer follows memory read valid by one cycle; blocked moves answer next cycle
      if (state_reg == ST_WAIT && mem_rvalid_i) begin
        move_done_reg <= 1'b1;
        move_rdata_reg <= mem_rdata_i;
      end else if (move_go_w && !issue_w) begin
        move_done_reg <= 1'b1;
        move_rdata_reg <= mapper_pkg::BLOCKED_READ_VALUE;
      end else begin
        move_done_reg <= move_go_w && umove_write_i;
      end
    end
  end

  // ==========================================================================
  // Pointer views
  logic [23:0] uptr0_reg;
  logic [23:0] uptr1_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uptr0_reg <= 24'h000000;
      uptr1_reg <= 24'h000000;
    end else begin
      uptr0_reg <= uptr0_w;
      uptr1_reg <= uptr1_w;
    end
  end

  assign pc_o = pc_reg;
  assign fetch_o = fetch_reg;
  assign decoded_valid_o = decoded_valid_reg;
  assign decoded_opcode_o = decoded_opcode_reg;
  assign extended_form_o = extended_form_reg;
  assign cread_o = cread_reg;
  assign mem_req_o = mem_req_reg;
  assign move_done_o = move_done_reg;
  assign move_rdata_o = move_rdata_reg;
  assign move_dropped_o = move_dropped_reg;
  assign busy_o = busy_reg;
  assign uptr0_o = uptr0_reg;
  assign uptr1_o = uptr1_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_prefix_then_opcode;
    is_prefix ##1 (opcode_valid_i && opcode_i != mapper_pkg::PREFIX_BYTE);
  endsequence

  sequence s_blocked_read;
    umove_req_i && !busy_reg && !umove_write_i && !umove_reach_w;
  endsequence

  a_reset_pc_start:
    assert property (disable iff (1'b0) $past(rst_i) && !pc_load_i && !pc_step_i
                     |-> pc_reg == mapper_pkg::RESET_PC)
    else $error("PC not at reset address after reset");
  a_fetch_upper_gate:
    assert property ((fetch_o.addr > mapper_pkg::CODE_LOW_TOP) && !$past(extended_addressing_enable_i)
                     |-> fetch_o.fault)
    else $error("Upper code fetched without extended addressing");
  a_cread_upper_gate:
    assert property (cread_o.valid && !cread_o.fault && cread_o.addr > mapper_pkg::CODE_LOW_TOP
                     |-> $past(extended_addressing_enable_i))
    else $error("Upper constant read without extended addressing");
  a_onchip_internal:
    assert property (fetch_o.addr <= ONCHIP_TOP && $past(bus_mode_i) == mapper_pkg::BUS_MIXED
                     |-> !fetch_o.external)
    else $error("On-chip code routed to external bus");
  a_single_chip_bus:
    assert property ($past(bus_mode_i) == mapper_pkg::BUS_SINGLE_CHIP |-> !fetch_o.external)
    else $error("External bus used in single chip mode");
  a_move_disp_added:
    assert property (umove_req_i && !busy_reg && umove_reach_w && !code_store_w
                     |=> mem_req_o.valid && mem_req_o.addr == uadd($past(umove_ptr_w),
                         {1'b0, $past(umove_disp_i)}))
    else $error("Universal move address wrong");
  a_code_store_blocked:
    assert property (mem_req_o.valid && mem_req_o.write |-> mem_req_o.space != mapper_pkg::SPACE_CODE)
    else $error("Store issued into code region");
  a_internal_not_sfr:
    assert property (mem_req_o.valid && mem_req_o.space == mapper_pkg::SPACE_INDIRECT_INTERNAL_DATA_SPACE
                     |-> mem_req_o.addr[23:8] == mapper_pkg::INDIRECT_INTERNAL_DATA_SPACE_BASE[23:8])
    else $error("Internal data access left internal range");
  a_blocked_read_ff:
    assert property (s_blocked_read |=> move_done_o && move_rdata_o == mapper_pkg::BLOCKED_READ_VALUE
                     && !mem_req_o.valid)
    else $error("Blocked read did not return FF");
  a_increment_in_place:
    assert property (uinc_req_i && !uinc_ptr_sel_i && !reg_wr_i ##1 1'b1
                     |=> uptr0_o == uadd($past(uptr0_w, 2), {1'b0, $past(uinc_amount_i, 2)} + 3'h1))
    else $error("Pointer increment wrong");
  a_prefix_extends:
    assert property (s_prefix_then_opcode |=> extended_form_o && decoded_valid_o)
    else $error("Prefixed opcode not in extended form");
  a_read_answer_timing:
    assert property (state_reg == ST_WAIT && mem_rvalid_i |=> move_done_o && !busy_o)
    else $error("Read answer not returned next cycle");

endmodule

// file: logic/mapper_pkg.sv
// Shared constants and types for the extended address mapper.
// Assumes a single core clock; all users reference mapper_pkg::name.
package mapper_pkg;

  // ==========================================================================
  // Widths
  localparam int PC_W = 23;
  localparam int UPTR_W = 24;
  localparam int NUM_BANKS = 4;
  localparam int REGS_PER_BANK = 8;

  // ==========================================================================
  // Addresses and boundaries
  localparam logic [22:0] RESET_PC = 23'h000000;
  localparam logic [22:0] VECTOR_BASE = 23'h000003;
  localparam logic [22:0] CODE_LOW_TOP = 23'h00FFFF;
  localparam logic [23:0] EXTERNAL_DATA_SPACE_TOP = 24'h00FFFF;
  localparam logic [23:0] HIGH_DATA_SPACE_TOP = 24'h7EFFFF;
  localparam logic [23:0] INDIRECT_INTERNAL_DATA_SPACE_BASE = 24'h7F0000;
  localparam logic [23:0] INDIRECT_INTERNAL_DATA_SPACE_TOP = 24'h7F00FF;
  localparam logic [23:0] EXTENDED_INTERNAL_DATA_SPACE_TOP = 24'h7FFFFF;
  localparam int CODE_SEL_BIT = 23;

  // ==========================================================================
  // Pointer register positions inside a bank, most significant first
  localparam logic [2:0] PTR0_HI = 3'h1;
  localparam logic [2:0] PTR0_MID = 3'h2;
  localparam logic [2:0] PTR0_LO = 3'h3;
  localparam logic [2:0] PTR1_HI = 3'h5;
  localparam logic [2:0] PTR1_MID = 3'h6;
  localparam logic [2:0] PTR1_LO = 3'h7;

  // ==========================================================================
  // Values
  localparam logic [7:0] PREFIX_BYTE = 8'hA5;
  localparam logic [7:0] BLOCKED_READ_VALUE = 8'hFF;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {BUS_MIXED, BUS_SINGLE_CHIP, BUS_ROMLESS} bus_mode_t;
  typedef enum logic [1:0] {BASE_ACTIVE_DATA_POINTER_16, BASE_EXTENDED_DATA_POINTER, BASE_UPTR, BASE_PC} base_sel_t;
  typedef enum logic [2:0] {
    SPACE_EXTERNAL_DATA_SPACE, SPACE_HIGH_DATA_SPACE, SPACE_INDIRECT_INTERNAL_DATA_SPACE, SPACE_EXTENDED_INTERNAL_DATA_SPACE, SPACE_CODE
  } space_t;

  typedef struct packed {
    logic valid;
    logic write;
    space_t space;
    logic [23:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic external;
    logic fault;
    logic [22:0] addr;
  } code_req_t;

endpackage

// file: logic/universal_map_decoder.sv
// Splits a universal pointer value into its memory space.
// Purely combinational; the caller registers the results.
module universal_map_decoder (
  // Pointer value and mode
  input wire logic [23:0] addr_i,
  input wire logic ext_enable_i,
  // Decoded space
  output mapper_pkg::space_t space_o,
  output logic reachable_o
);

  // ==========================================================================
  // Space ranges, bottom to top: external, high, internal, extended, code
  wire is_code = addr_i[mapper_pkg::CODE_SEL_BIT];
  wire is_external_data_space = !is_code && (addr_i <= mapper_pkg::EXTERNAL_DATA_SPACE_TOP);
  wire is_high_data_space = !is_code && !is_external_data_space && (addr_i <= mapper_pkg::HIGH_DATA_SPACE_TOP);
  wire is_indirect_internal_data_space = !is_code && (addr_i >= mapper_pkg::INDIRECT_INTERNAL_DATA_SPACE_BASE)
                  && (addr_i <= mapper_pkg::INDIRECT_INTERNAL_DATA_SPACE_TOP);
  wire code_low = ({1'b0, addr_i[22:0]} <= {1'b0, mapper_pkg::CODE_LOW_TOP});

  assign space_o = is_code ? mapper_pkg::SPACE_CODE :
                   is_external_data_space ? mapper_pkg::SPACE_EXTERNAL_DATA_SPACE :
                   is_high_data_space ? mapper_pkg::SPACE_HIGH_DATA_SPACE :
                   is_indirect_internal_data_space ? mapper_pkg::SPACE_INDIRECT_INTERNAL_DATA_SPACE : mapper_pkg::SPACE_EXTENDED_INTERNAL_DATA_SPACE;

  // Internal spaces stay reachable in both modes
  assign reachable_o = ext_enable_i || (is_code ? code_low : !is_high_data_space);

endmodule

// file: logic/code_fetch_router.sv
// Decides whether a code address goes on-chip or to the external bus.
// Purely combinational; bus mode comes from core configuration.
module code_fetch_router #(
  parameter logic [22:0] ONCHIP_TOP = 23'h017FFF
) (
  // Code address and mode
  input wire logic [22:0] addr_i,
  input wire logic ext_enable_i,
  input wire mapper_pkg::bus_mode_t bus_mode_i,
  // Routing result
  output logic external_o,
  output logic fault_o
);

  // ==========================================================================
  // Routing
  wire above_onchip = (addr_i > ONCHIP_TOP);
  wire above_low = (addr_i > mapper_pkg::CODE_LOW_TOP);
  wire want_external = (bus_mode_i == mapper_pkg::BUS_ROMLESS) || above_onchip;

  assign external_o = want_external && (bus_mode_i != mapper_pkg::BUS_SINGLE_CHIP);
  // Upper code needs extended mode; single chip has nothing off-chip
  assign fault_o = (above_low && !ext_enable_i)
                   || (want_external && bus_mode_i == mapper_pkg::BUS_SINGLE_CHIP);

endmodule

// file: dv/ext_memory_model.sv
// Behavioural off-chip memory that answers the mapper's read requests.
// Assumes requests are one-cycle pulses; stores are accepted silently.
module ext_memory_model #(
  parameter int LAT = 3
) (
  input wire logic clk_i,
  input wire mapper_pkg::mem_req_t req_i,
  output logic rvalid_o,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] held;
  // ==========================================================================
  // Read answer after a fixed latency; the bus shows junk once released
  initial begin
    rvalid_o = 1'b0;
    rdata_o = 8'h00;
    forever begin
      @(posedge clk_i);
      #1;
      if (req_i.valid === 1'b1 && req_i.write === 1'b0) begin
        held = req_i.addr[7:0] ^ 8'hC3;
        repeat (LAT) @(posedge clk_i);
        #1 rvalid_o = 1'b1;
        rdata_o = held;
        @(posedge clk_i);
        #1 rvalid_o = 1'b0;
        rdata_o = ~held;
      end
    end
  end
endmodule

// file: dv/extended_address_mapper_tb.sv
// Self-checking bench for the extended address mapper.
// Assumes the design's own assertions run alongside; memory is modelled.
module extended_address_mapper_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic extended_addressing_enable_i, reg_wr_i, pc_step_i, pc_load_i, opcode_valid_i;
  logic cread_req_i, cread_ptr_sel_i, umove_req_i, umove_write_i, umove_ptr_sel_i;
  logic uinc_req_i, uinc_ptr_sel_i, mem_rvalid_i;
  mapper_pkg::bus_mode_t bus_mode_i;
  mapper_pkg::base_sel_t cread_base_i;
  logic [1:0] bank_sel_i, umove_disp_i, uinc_amount_i;
  logic [2:0] reg_wr_idx_i, pc_step_len_i;
  logic [7:0] reg_wr_data_i, opcode_i, acc_i, mem_rdata_i, decoded_opcode_o, move_rdata_o;
  logic [15:0] active_data_pointer_16_i;
  logic [22:0] pc_load_addr_i, extended_data_pointer_i, pc_o;
  mapper_pkg::code_req_t fetch_o, cread_o;
  mapper_pkg::mem_req_t mem_req_o;
  logic decoded_valid_o, extended_form_o, move_done_o, move_dropped_o, busy_o;
  logic [23:0] uptr0_o, uptr1_o;
  int mismatches = 0;
  int check_count = 0;

  always #4 clk_i = ~clk_i;

  extended_address_mapper i_dut (.clk_i, .rst_i, .extended_addressing_enable_i, .bus_mode_i,
    .bank_sel_i, .reg_wr_i, .reg_wr_idx_i, .reg_wr_data_i, .pc_step_i, .pc_step_len_i,
    .pc_load_i, .pc_load_addr_i, .opcode_valid_i, .opcode_i, .cread_req_i, .cread_base_i,
    .cread_ptr_sel_i, .acc_i, .active_data_pointer_16_i, .extended_data_pointer_i, .umove_req_i, .umove_write_i,
    .umove_ptr_sel_i, .umove_disp_i, .uinc_req_i, .uinc_ptr_sel_i, .uinc_amount_i,
    .mem_rvalid_i, .mem_rdata_i, .pc_o, .fetch_o, .decoded_valid_o, .decoded_opcode_o,
    .extended_form_o, .cread_o, .mem_req_o, .move_done_o, .move_rdata_o, .move_dropped_o,
    .busy_o, .uptr0_o, .uptr1_o);

  ext_memory_model i_mem (.clk_i(clk_i), .req_i(mem_req_o), .rvalid_o(mem_rvalid_i),
    .rdata_o(mem_rdata_i));

  // ==========================================================================
  // Shared helpers
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic fetch_case(input logic [22:0] a, input logic en,
                            input mapper_pkg::bus_mode_t m, input logic ext, input logic flt);
    extended_addressing_enable_i = en;
    bus_mode_i = m;
    pc_load_addr_i = a;
    pc_load_i = 1'b1;
    tick();
    pc_load_i = 1'b0;
    chk("pc", pc_o, a);
    chk("fetch addr", fetch_o.addr, a);
    chk("fetch fault", fetch_o.fault, flt);
    chk("fetch ext", fetch_o.external, ext);
  endtask

  task automatic cread_case(input mapper_pkg::base_sel_t b, input logic [22:0] a,
                            input logic flt);
    cread_base_i = b;
    cread_req_i = 1'b1;
    tick();
    cread_req_i = 1'b0;
    chk("cread valid", cread_o.valid, 1'b1);
    chk("cread addr", cread_o.addr, a);
    chk("cread fault", cread_o.fault, flt);
  endtask

  task automatic set_ptr(input logic sel, input logic [23:0] v);
    reg_wr_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      reg_wr_idx_i = (sel ? 3'h5 : 3'h1) + 3'(i);
      reg_wr_data_i = v[23 - 8 * i -: 8];
      tick();
    end
    reg_wr_i = 1'b0;
    tick();
    chk("uptr", sel ? uptr1_o : uptr0_o, v);
  endtask

  task automatic umove(input logic sel, input logic wr, input logic [1:0] d, input logic rv,
                       input mapper_pkg::space_t sp, input logic [23:0] a, input logic [7:0] dt);
    int n;
    umove_ptr_sel_i = sel;
    umove_write_i = wr;
    umove_disp_i = d;
    umove_req_i = 1'b1;
    tick();
    umove_req_i = 1'b0;
    chk("req valid", mem_req_o.valid, rv);
    if (rv) chk("req addr", mem_req_o.addr, a);
    if (rv) chk("req space", mem_req_o.space, sp);
    if (rv) chk("req write", mem_req_o.write, wr);
    if (rv && !wr) chk("busy", busy_o, 1'b1);
    if (rv && wr) chk("req wdata", mem_req_o.wdata, acc_i);
    for (n = 0; n < 20 && move_done_o !== 1'b1; n++) tick();
    chk("done", move_done_o, 1'b1);
    if (wr) chk("dropped", move_dropped_o, !rv);
    else chk("rdata", move_rdata_o, dt);
    tick();
  endtask

  task automatic op(input logic [7:0] b, input logic dv, input logic ef);
    opcode_i = b;
    opcode_valid_i = 1'b1;
    tick();
    opcode_valid_i = 1'b0;
    chk("decoded valid", decoded_valid_o, dv);
    if (dv) chk("extended form", extended_form_o, ef);
    if (dv) chk("opcode", decoded_opcode_o, b);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    {extended_addressing_enable_i, reg_wr_i, pc_step_i, pc_load_i, opcode_valid_i} = '0;
    {cread_req_i, cread_ptr_sel_i, umove_req_i, umove_write_i, umove_ptr_sel_i} = '0;
    {uinc_req_i, uinc_ptr_sel_i, bank_sel_i, umove_disp_i, uinc_amount_i} = '0;
    {reg_wr_idx_i, pc_step_len_i, reg_wr_data_i, opcode_i, acc_i} = '0;
    {active_data_pointer_16_i, pc_load_addr_i, extended_data_pointer_i} = '0;
    bus_mode_i = mapper_pkg::BUS_MIXED;
    cread_base_i = mapper_pkg::BASE_ACTIVE_DATA_POINTER_16;
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'b0;
    tick();
    chk("reset pc", pc_o, 23'h000000);
    chk("reset fetch", fetch_o.valid, 1'b1);
    // Stimulus never places the extended jump at address zero
    fetch_case(23'h7FFFFF, 1'b1, mapper_pkg::BUS_MIXED, 1'b1, 1'b0);
    fetch_case(23'h010000, 1'b0, mapper_pkg::BUS_MIXED, 1'b0, 1'b1);
    fetch_case(23'h017FFF, 1'b1, mapper_pkg::BUS_MIXED, 1'b0, 1'b0);
    fetch_case(23'h018000, 1'b1, mapper_pkg::BUS_SINGLE_CHIP, 1'b0, 1'b1);
    fetch_case(23'h000010, 1'b0, mapper_pkg::BUS_ROMLESS, 1'b1, 1'b0);
    fetch_case(23'h020000, 1'b1, mapper_pkg::BUS_MIXED, 1'b1, 1'b0);
    active_data_pointer_16_i = 16'hFFF0;
    extended_data_pointer_i = 23'h123456;
    acc_i = 8'h20;
    cread_case(mapper_pkg::BASE_ACTIVE_DATA_POINTER_16, 23'h020010, 1'b0);
    cread_case(mapper_pkg::BASE_EXTENDED_DATA_POINTER, 23'h123476, 1'b0);
    cread_case(mapper_pkg::BASE_PC, 23'h020020, 1'b0);
    pc_step_len_i = 3'h3;
    pc_step_i = 1'b1;
    tick();
    pc_step_i = 1'b0;
    chk("pc step", pc_o, 23'h020003);
    set_ptr(1'b0, 24'h800100);
    uinc_amount_i = 2'h3;
    uinc_req_i = 1'b1;
    tick();
    uinc_req_i = 1'b0;
    tick();
    chk("uptr0 inc", uptr0_o, 24'h800104);
    set_ptr(1'b1, 24'h001234);
    cread_ptr_sel_i = 1'b1;
    cread_case(mapper_pkg::BASE_UPTR, 23'h001254, 1'b0);
    umove(1'b1, 1'b0, 2'h3, 1'b1, mapper_pkg::SPACE_EXTERNAL_DATA_SPACE, 24'h001237, 8'hF4);
    acc_i = 8'h5A;
    umove(1'b0, 1'b1, 2'h0, 1'b0, mapper_pkg::SPACE_CODE, 24'h800104, 8'h00);
    umove(1'b1, 1'b1, 2'h1, 1'b1, mapper_pkg::SPACE_EXTERNAL_DATA_SPACE, 24'h001235, 8'h00);
    extended_addressing_enable_i = 1'b0;
    cread_case(mapper_pkg::BASE_EXTENDED_DATA_POINTER, 23'h1234B0, 1'b1);
    set_ptr(1'b1, 24'h010000);
    umove(1'b1, 1'b0, 2'h0, 1'b0, mapper_pkg::SPACE_HIGH_DATA_SPACE, 24'h010000, 8'hFF);
    set_ptr(1'b1, 24'h7F0200);
    umove(1'b1, 1'b0, 2'h0, 1'b1, mapper_pkg::SPACE_EXTENDED_INTERNAL_DATA_SPACE, 24'h7F0200, 8'hC3);
    op(8'hA5, 1'b0, 1'b0);
    op(8'h02, 1'b1, 1'b1);
    op(8'h02, 1'b1, 1'b0);
    complete_run();
  end

  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule
